// ### hdl/hiss_consts.svh
// constants of the host interface select and serial port block
`ifndef HISS_CONSTS_SVH
`define HISS_CONSTS_SVH
`define HISS_HDR_ADAD_NI    8'h40
`define HISS_HDR_ADAD_IL    8'h48
`define HISS_HDR_ADDD_RW    8'h43
`define HISS_HDR_ADDD_NI    8'h41
`define HISS_HDR_ADDD_IL    8'h49
`define HISS_BYTE_BITS      4'h8
`define HISS_BIT_CNT_W      3
`define HISS_MCLK_DIV       4'h4
`define HISS_ADDR_W         7
`define HISS_RD_FLAG_BIT    7
`define HISS_STRAP_WAIT     2'h2
`endif

// ### hdl/hiss_pkg.sv
// types of the host interface select and serial port block
package hiss_pkg;
  typedef enum logic [4:0] {
    HISS_IF_PAR_STROBE_DIR = 5'h01,
    HISS_IF_PAR_NONMUX     = 5'h02,
    HISS_IF_PAR_MUX        = 5'h04,
    HISS_IF_SERIAL_PORT    = 5'h08,
    HISS_IF_MONITOR_SLAVE  = 5'h10
  } hiss_if_t;

  typedef enum logic [3:0] {
    HISS_ST_HEADER = 4'h1,
    HISS_ST_ADDR   = 4'h2,
    HISS_ST_DATA   = 4'h4,
    HISS_ST_IGNORE = 4'h8
  } hiss_state_t;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } hiss_reg_req_t;
endpackage

// ### hdl/hiss_top.sv
// host interface selection, serial control port and monitor slave entry
//
// Overview of operation
// - sample straps once at reset release
// - strobes high, chip select either level: parallel bus
// - strobes low, latch low: serial or monitor
// - monitor slave mode takes master register writes
// - interrupt low while any request pends
// - generate clock output for microcontroller
// - four-line port: clock, in, out, select
// - chip select falling edge starts access
// - capture on rising, shift on falling edge
// - eight-bit groups, most significant bit first
// - config bit picks open drain or push-pull
// - header byte selects the programming sequence
// - latch edge in a parallel mode (strobe/direction or non-muxed) forces multiplexed bus until reset
`timescale 1ns/100ps
`default_nettype none
`include "hiss_consts.svh"

module hiss_top
  import hiss_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          strap_wr,
  input  wire logic          strap_rd,
  input  wire logic          chip_sel_n,
  input  wire logic          addr_latch,
  input  wire logic          serial_clk,
  input  wire logic          serial_data_in,
  input  wire logic          serial_out_push_pull_sel,
  input  wire logic          mon_valid,
  input  wire hiss_reg_req_t mon_req,
  input  wire logic [7:0]    irq_pending,
  input  wire logic [7:0]    reg_rdata,
  output logic               serial_data_out,
  output logic               serial_data_out_oe_n,
  output logic               irq_n_out,
  output logic               irq_n_oe_n,
  output logic               mcu_clk,
  output logic [4:0]         if_sel,
  output logic               reg_valid,
  output hiss_reg_req_t      reg_req
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] pins;
  assign pins = {strap_wr, strap_rd, chip_sel_n, addr_latch, serial_clk, serial_data_in};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 6'h3F;
      sync2_q <= 6'h3F;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  logic s_wr, s_rd, s_cs_n, s_ale, s_sclk, s_sdi;
  assign {s_wr, s_rd, s_cs_n, s_ale, s_sclk, s_sdi} = sync2_q;

  logic cs_q, sclk_q, ale_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q   <= 1'b1;
      sclk_q <= 1'b1;
      ale_q  <= 1'b1;
    end else begin
      cs_q   <= s_cs_n;
      sclk_q <= s_sclk;
      ale_q  <= s_ale;
    end
  end

  logic cs_fall, cs_rise, sclk_rise, sclk_fall, ale_edge;
  assign cs_fall   = cs_q & ~s_cs_n;
  assign cs_rise   = ~cs_q & s_cs_n;
  assign sclk_rise = ~sclk_q & s_sclk;
  assign sclk_fall = sclk_q & ~s_sclk;
  assign ale_edge  = ale_q ^ s_ale;

  // ------------------------------------------------------------
  // strap evaluation
  // ------------------------------------------------------------
  // straps reach the decoder through the synchronisers, two clocks after release
  logic       strapped_q;
  logic [1:0] strap_cnt_q;
  hiss_if_t   if_q;

  function automatic hiss_if_t decode_straps(input logic wr, input logic rd,
                                             input logic cs_n, input logic ale);
    hiss_if_t r;
    r = HISS_IF_PAR_NONMUX;
    if (wr && rd)
      r = ale ? HISS_IF_PAR_STROBE_DIR : HISS_IF_PAR_NONMUX;
    else if (!wr && !rd && !ale)
      r = cs_n ? HISS_IF_SERIAL_PORT : HISS_IF_MONITOR_SLAVE;
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapped_q  <= 1'b0;
      strap_cnt_q <= 2'h0;
      if_q        <= HISS_IF_PAR_NONMUX;
    end else if (!strapped_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      strapped_q  <= (strap_cnt_q == `HISS_STRAP_WAIT);
      if_q        <= decode_straps(s_wr, s_rd, s_cs_n, s_ale);
    end else if (ale_edge && (if_q[1:0] != 2'b00 || if_q == HISS_IF_PAR_MUX)) begin
      if_q <= HISS_IF_PAR_MUX;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      if_sel <= 5'h00;
    else
      if_sel <= strapped_q ? if_q : 5'h00;
  end

  logic sp_en;
  assign sp_en = strapped_q && (if_q == HISS_IF_SERIAL_PORT);

  // ------------------------------------------------------------
  // serial byte shifter
  // ------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       active_q;

  assign rx_byte   = {rx_sh_q[6:0], s_sdi};
  assign byte_done = sp_en && active_q && sclk_rise && (bit_cnt_q == 3'h7);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q  <= 1'b0;
      bit_cnt_q <= 3'h0;
      rx_sh_q   <= 8'h00;
    end else if (!sp_en || cs_rise) begin
      active_q  <= 1'b0;
      bit_cnt_q <= 3'h0;
    end else if (cs_fall) begin
      active_q  <= 1'b1;
      bit_cnt_q <= 3'h0;
    end else if (active_q && sclk_rise) begin
      // data line taken on clock rise, msb first
      rx_sh_q   <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // ------------------------------------------------------------
  // sequence decoder
  // ------------------------------------------------------------
  hiss_state_t st_q;
  logic [7:0]  hdr_q;
  logic [6:0]  addr_q;
  logic        rd_q;
  logic        in_read_q;

  function automatic logic is_burst(input logic [7:0] h);
    return (h == `HISS_HDR_ADDD_RW) || (h == `HISS_HDR_ADDD_NI) || (h == `HISS_HDR_ADDD_IL);
  endfunction

  function automatic logic hdr_known(input logic [7:0] h);
    return is_burst(h) || (h == `HISS_HDR_ADAD_NI) || (h == `HISS_HDR_ADAD_IL);
  endfunction

  logic          sp_req_valid;
  hiss_reg_req_t sp_req;
  logic          rd_fetch;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= HISS_ST_HEADER;
      hdr_q        <= 8'h00;
      addr_q       <= 7'h00;
      rd_q         <= 1'b0;
      sp_req_valid <= 1'b0;
      sp_req       <= '0;
      rd_fetch     <= 1'b0;
    end else begin
      sp_req_valid <= 1'b0;
      rd_fetch     <= 1'b0;
      if (!active_q || cs_fall) begin
        st_q <= HISS_ST_HEADER;
      end else if (byte_done) begin
        case (st_q)
          HISS_ST_HEADER: begin
            hdr_q <= rx_byte;
            st_q  <= hdr_known(rx_byte) ? HISS_ST_ADDR : HISS_ST_IGNORE;
          end
          HISS_ST_ADDR: begin
            addr_q <= rx_byte[6:0];
            rd_q   <= rx_byte[`HISS_RD_FLAG_BIT];
            if (rx_byte[`HISS_RD_FLAG_BIT]) begin
              // read address: fetch data, next byte is data for header 43h, else address again
              sp_req_valid <= 1'b1;
              sp_req       <= '{wr: 1'b0, addr: rx_byte[6:0], data: 8'h00};
              rd_fetch     <= 1'b1;
              st_q         <= (hdr_q == `HISS_HDR_ADDD_RW) ? HISS_ST_DATA : HISS_ST_ADDR;
            end else begin
              st_q <= HISS_ST_DATA;
            end
          end
          HISS_ST_DATA: begin
            if (!rd_q) begin
              sp_req_valid <= 1'b1;
              sp_req       <= '{wr: 1'b1, addr: addr_q, data: rx_byte};
            end else begin
              sp_req_valid <= 1'b1;
              sp_req       <= '{wr: 1'b0, addr: addr_q, data: 8'h00};
              rd_fetch     <= 1'b1;
            end
            st_q <= is_burst(hdr_q) ? HISS_ST_DATA : HISS_ST_ADDR;
          end
          HISS_ST_IGNORE: st_q <= HISS_ST_IGNORE;
          default:        st_q <= HISS_ST_HEADER;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register request mux (serial port or monitor slave)
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_valid <= 1'b0;
      reg_req   <= '0;
    end else if (if_q == HISS_IF_MONITOR_SLAVE && strapped_q) begin
      reg_valid <= mon_valid;
      reg_req   <= mon_req;
    end else begin
      reg_valid <= sp_req_valid;
      reg_req   <= sp_req;
    end
  end

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  logic [7:0] tx_sh_q;
  logic [7:0] tx_next_q;
  logic [2:0] tx_cnt_q;
  logic       tx_load_q;
  logic       tx_pend_q;
  logic       tx_act_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_load_q <= 1'b0;
      tx_pend_q <= 1'b0;
      tx_next_q <= 8'h00;
      tx_sh_q   <= 8'h00;
      tx_cnt_q  <= 3'h0;
      tx_act_q  <= 1'b0;
    end else begin
      // read data is taken in the cycle reg_valid is high
      tx_load_q <= rd_fetch;
      if (!active_q) begin
        tx_pend_q <= 1'b0;
        tx_act_q  <= 1'b0;
      end else if (tx_load_q) begin
        tx_next_q <= reg_rdata;
        tx_pend_q <= 1'b1;
      end else if (sclk_fall && (tx_pend_q || tx_act_q)) begin
        // output moves on clock fall; a waiting byte starts, else shift
        tx_pend_q <= 1'b0;
        tx_act_q  <= tx_pend_q || (tx_cnt_q != 3'h7);
        tx_sh_q   <= tx_pend_q ? tx_next_q : {tx_sh_q[6:0], 1'b0};
        tx_cnt_q  <= tx_pend_q ? 3'h0 : tx_cnt_q + 3'h1;
      end
    end
  end

  // release outside read bytes; driver style
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out      <= 1'b1;
      serial_data_out_oe_n <= 1'b1;
    end else if (tx_act_q && active_q) begin
      serial_data_out      <= tx_sh_q[7];
      serial_data_out_oe_n <= serial_out_push_pull_sel ? 1'b0 : tx_sh_q[7];
    end else begin
      serial_data_out      <= 1'b1;
      serial_data_out_oe_n <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // interrupt and microcontroller clock
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_out  <= 1'b0;
      irq_n_oe_n <= 1'b1;
    end else begin
      irq_n_out  <= 1'b0;
      irq_n_oe_n <= ~(|irq_pending);
    end
  end

  logic [3:0] mclk_cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_cnt_q <= 4'h0;
      mcu_clk    <= 1'b0;
    end else if (mclk_cnt_q == `HISS_MCLK_DIV - 4'h1) begin
      mclk_cnt_q <= 4'h0;
      mcu_clk    <= ~mcu_clk;
    end else begin
      mclk_cnt_q <= mclk_cnt_q + 4'h1;
    end
  end

endmodule

`default_nettype wire

// ### tb/hiss_top_asserts.sv
// checker for the host interface select and serial port block
`timescale 1ns/100ps
`default_nettype none
module hiss_top_asserts
  import hiss_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          chip_sel_n,
  input wire logic          serial_out_push_pull_sel,
  input wire logic          mon_valid,
  input wire hiss_reg_req_t mon_req,
  input wire logic [7:0]    irq_pending,
  input wire logic          serial_data_out,
  input wire logic          serial_data_out_oe_n,
  input wire logic          irq_n_out,
  input wire logic          irq_n_oe_n,
  input wire logic          mcu_clk,
  input wire logic [4:0]    if_sel,
  input wire logic          reg_valid,
  input wire hiss_reg_req_t reg_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hold3; $stable(mcu_clk) [*3]; endsequence
  sequence s_idle; chip_sel_n [*5]; endsequence
  sequence s_od; !serial_out_push_pull_sel [*3]; endsequence
  property p_mclk; $changed(mcu_clk) |=> s_hold3 ##1 $changed(mcu_clk); endproperty
  property p_irq_on; irq_pending != 8'h00 |-> ##[1:3] (!irq_n_oe_n && !irq_n_out); endproperty
  property p_irq_off; (irq_pending == 8'h00) [*3] |-> irq_n_oe_n; endproperty
  property p_mon;
    if_sel == HISS_IF_MONITOR_SLAVE && mon_valid |=> reg_valid && reg_req == $past(mon_req);
  endproperty
  property p_sticky; if_sel == HISS_IF_PAR_MUX |=> if_sel == HISS_IF_PAR_MUX; endproperty
  property p_hold;
    if_sel != 5'h00 |=> if_sel == $past(if_sel) || if_sel == HISS_IF_PAR_MUX;
  endproperty
  property p_onehot; if_sel != 5'h00 |-> $onehot(if_sel); endproperty
  property p_idle; s_idle |-> serial_data_out_oe_n; endproperty
  property p_od; s_od ##0 !serial_data_out_oe_n |-> !serial_data_out; endproperty
  a_mclk: assert property (p_mclk) else $error("mcu clock period wrong");
  a_irq_on: assert property (p_irq_on) else $error("interrupt not driven");
  a_irq_off: assert property (p_irq_off) else $error("interrupt not released");
  a_mon: assert property (p_mon) else $error("monitor request lost");
  a_sticky: assert property (p_sticky) else $error("mux bus left");
  a_hold: assert property (p_hold) else $error("interface choice changed");
  a_onehot: assert property (p_onehot) else $error("interface choice not one-hot");
  a_idle: assert property (p_idle) else $error("data out driven while idle");
  a_od: assert property (p_od) else $error("open drain drives high");
endmodule
bind hiss_top hiss_top_asserts hiss_top_asserts_inst (.*);
`default_nettype wire

// ### tb/hiss_host_model.sv
// host side of the four-line serial port: shifts one byte per start pulse
`timescale 1ns/100ps
`default_nettype none
module hiss_host_model #(parameter int HALF = 8) (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] tx,
  input  wire logic       sdo_wire,
  output logic            sclk,
  output logic            sdi,
  output logic [7:0]      rx,
  output logic            done
);
  initial {sclk, sdi, rx, done} = 11'h200;
  // msb first, data set while clock low
  always @(posedge clk) if (start) begin
    for (int i = 7; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      rx[i] <= sdo_wire;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    sdi <= ~tx[0];
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  end
endmodule
`default_nettype wire

// ### tb/host_interface_select_serial_port_bench.sv
// self-checking bench of the host interface select and serial port block
`timescale 1ns/100ps
`default_nettype none
module host_interface_select_serial_port_bench;
  import hiss_pkg::*;
  logic          clk, rst_n, strap_wr, strap_rd, chip_sel_n, addr_latch, serial_clk;
  logic          serial_data_in, serial_out_push_pull_sel, mon_valid, reg_valid, start, done;
  logic          serial_data_out, serial_data_out_oe_n, irq_n_out, irq_n_oe_n, mcu_clk;
  logic [7:0]    irq_pending, reg_rdata, tx, rx, r, a, d;
  logic [4:0]    if_sel;
  hiss_reg_req_t mon_req, reg_req, got;
  int            miscompares = 0, compares = 0, cyc = 0;
  logic [3:0]    straps [4] = '{4'hF, 4'hE, 4'h2, 4'h0};
  hiss_if_t      exp_sel [4] = '{HISS_IF_PAR_STROBE_DIR, HISS_IF_PAR_NONMUX,
                                 HISS_IF_SERIAL_PORT, HISS_IF_MONITOR_SLAVE};
  logic [7:0]    hdrs [5] = '{8'h40, 8'h48, 8'h41, 8'h49, 8'h43};
  wire           sdo_wire = serial_data_out_oe_n ? 1'b1 : serial_data_out;
  hiss_top hiss_top_inst (.*);
  hiss_host_model hiss_host_model_inst (.sclk(serial_clk), .sdi(serial_data_in), .*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reg_valid === 1'b1) got <= reg_req;
    if (cyc == 30000) begin
      miscompares++;
      test_done();
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task test_done();
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task do_reset(input logic [3:0] s);
    rst_n <= 1'b0;
    {strap_wr, strap_rd, chip_sel_n, addr_latch} <= s;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task xfer(input logic [7:0] b);
    int n;
    tx <= b;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 300);
    r = rx;
  endtask
  initial begin
    void'($urandom(32'h202ba706));
    {rst_n, strap_wr, strap_rd, chip_sel_n, addr_latch} = 5'h02;
    {serial_out_push_pull_sel, mon_valid, start, mon_req} = '0;
    {irq_pending, reg_rdata, tx} = '0;
    for (int i = 0; i < 4; i++) begin
      do_reset(straps[i]);
      chk(16'(if_sel), 16'(exp_sel[i]));
    end
    repeat (6) begin
      mon_req <= hiss_reg_req_t'(16'($urandom));
      mon_valid <= 1'b1;
      @(posedge clk);
      mon_valid <= 1'b0;
      repeat (3) @(posedge clk);
      chk(got, mon_req);
    end
    do_reset(4'hE);
    strap_wr <= 1'b0;
    repeat (6) @(posedge clk);
    chk(16'(if_sel), 16'(HISS_IF_PAR_NONMUX));
    addr_latch <= 1'b1;
    repeat (6) @(posedge clk);
    chk(16'(if_sel), 16'(HISS_IF_PAR_MUX));
    for (int i = 0; i < 4; i++) begin
      irq_pending <= (i == 3) ? 8'h00 : 8'($urandom_range(255, 1));
      repeat (4) @(posedge clk);
      chk(16'(irq_n_oe_n), 16'(irq_pending == 8'h00));
    end
    do_reset(4'h2);
    foreach (hdrs[i]) begin
      serial_out_push_pull_sel <= i[0];
      a = 8'($urandom_range(127));
      d = 8'($urandom);
      reg_rdata <= 8'($urandom);
      chip_sel_n <= 1'b0;
      repeat (5) @(posedge clk);
      xfer(hdrs[i]);
      xfer(a | 8'h80);
      chk(got, {1'b0, a[6:0], 8'h00});
      // header 43h read keeps its address; other headers take the write address meanwhile
      xfer((hdrs[i] == 8'h43) ? 8'h00 : a);
      chk(16'(r), 16'(reg_rdata));
      if (hdrs[i] != 8'h43) begin
        xfer(d);
        chk(got, {1'b1, a[6:0], d});
      end
      chip_sel_n <= 1'b1;
      repeat (8) @(posedge clk);
    end
    // unknown header: the rest of the access must be ignored
    chip_sel_n <= 1'b0;
    repeat (5) @(posedge clk);
    xfer(8'h42);
    xfer(a);
    xfer(d ^ 8'hFF);
    chk(got, {1'b0, a[6:0], 8'h00});
    chip_sel_n <= 1'b1;
    repeat (8) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
